// [hdl/ecs_pkg.sv]
// Purpose: shared constants and types of the enhanced pwm/compare unit
// Assumes: 32-bit ahb-lite register bus, one clock hclk
// Notes: offsets are byte addresses of aligned words
package ecs_pkg;

	// ****************************************************************
	// register map
	// ****************************************************************
	localparam logic [7:0] ECS_OFF_CTRL = 8'h00;
	localparam logic [7:0] ECS_OFF_DUTY = 8'h04;
	localparam logic [7:0] ECS_OFF_PERIOD = 8'h08;
	localparam logic [7:0] ECS_OFF_COMPARE = 8'h0c;
	localparam logic [7:0] ECS_OFF_STATUS = 8'h10;
	localparam logic [7:0] ECS_OFF_SHADOW = 8'h14;
	localparam logic [7:0] ECS_OFF_CONFIG = 8'h18;
	localparam logic [7:0] ECS_OFF_CAPTURE = 8'h1c;

	// ****************************************************************
	// reset values and field positions
	// ****************************************************************
	localparam logic [7:0] ECS_RST_CTRL = 8'h00;
	localparam logic [7:0] ECS_RST_DUTY = 8'h00;
	localparam logic [7:0] ECS_RST_PERIOD = 8'hff;
	localparam logic [15:0] ECS_RST_COMPARE = 16'hffff;
	localparam logic [15:0] ECS_RST_CONFIG = 16'h0003;
	localparam int ECS_CFG_REMAP = 0;
	localparam int ECS_CFG_PINSEL = 1;
	localparam int ECS_CFG_MEM_LO = 2;
	localparam int ECS_CFG_UNIT_LO = 4;
	localparam int ECS_CFG_ADC = 6;
	localparam int ECS_CFG_DB_LO = 8;
	localparam int ECS_ST_MATCH = 0;
	localparam int ECS_ST_CAPT = 1;

	// ****************************************************************
	// mode codes and constants
	// ****************************************************************
	localparam logic [3:0] ECS_M_OFF = 4'h0;
	localparam logic [3:0] ECS_M_RSVD = 4'h1;
	localparam logic [3:0] ECS_M_TOGGLE = 4'h2;
	localparam logic [3:0] ECS_M_CAP_ANY = 4'h3;
	localparam logic [3:0] ECS_M_CAP_FALL = 4'h4;
	localparam logic [3:0] ECS_M_CAP_RISE = 4'h5;
	localparam logic [3:0] ECS_M_CAP_R4 = 4'h6;
	localparam logic [3:0] ECS_M_CAP_R16 = 4'h7;
	localparam logic [3:0] ECS_M_CMP_HI = 4'h8;
	localparam logic [3:0] ECS_M_CMP_LO = 4'h9;
	localparam logic [3:0] ECS_M_CMP_SW = 4'ha;
	localparam logic [3:0] ECS_M_CMP_EVT = 4'hb;
	localparam logic [1:0] ECS_OC_SINGLE = 2'h0;
	localparam logic [1:0] ECS_OC_FWD = 2'h1;
	localparam logic [1:0] ECS_OC_HALF = 2'h2;
	localparam logic [1:0] ECS_OC_REV = 2'h3;
	localparam logic [1:0] ECS_MEM_ADDR12 = 2'h2;
	localparam logic [1:0] ECS_UNIT_SECOND = 2'h1;
	localparam logic [1:0] ECS_UNIT_THIRD = 2'h2;
	localparam logic [3:0] ECS_PRE_R4 = 4'h3;
	localparam logic [3:0] ECS_PRE_R16 = 4'hf;

	typedef enum logic [1:0] {
		ECS_BUS_IDLE = 2'b00,
		ECS_BUS_WRITE = 2'b01,
		ECS_BUS_READ = 2'b11
	} ecs_bus_type;

	// pin levels and ownership (own high: unit drives the pin)
	typedef struct packed {
		logic a_lvl;
		logic a_own;
		logic a2_lvl;
		logic a2_own;
		logic a3_lvl;
		logic a3_own;
		logic b_lvl;
		logic b_own;
		logic c_lvl;
		logic c_own;
		logic balt_lvl;
		logic balt_own;
		logic calt_lvl;
		logic calt_own;
		logic d_lvl;
		logic d_own;
		logic shared_lvl;
	} ecs_pins_type;

	// one-cycle event pulses toward timers and converter
	typedef struct packed {
		logic timer_reset;
		logic adc_start;
	} ecs_event_type;

	// system context inputs
	typedef struct packed {
		logic bus_active;
		logic ext_mode;
		logic std_unit_out;
	} ecs_sys_type;

endpackage

// [hdl/ecs_top.sv]
// Purpose: mode decode, compare, capture, pwm and output steering
// Assumes: single ahb-lite slave, zero wait states, hclk 25 MHz
// Notes: all pin outputs are registered, one cycle behind the state
//
// The placing of the registers and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

// Contract
// RULE1 - mode 0000 disables and resets; 0001 reserved
// RULE2 - capture modes: fall, rise, 4th, 16th rise
// RULE3 - mode 0010 toggles output on match
// RULE4 - 1000/1001 init level, drive on match, flag
// RULE5 - 1010 only flags; pin back to port
// RULE6 - 1011 resets timer, flags, starts converter
// RULE7 - 11xx pwm; low bits set output polarities
// RULE8 - non-pwm ignores output config; A only
// RULE9 - config 00 modulates A only
// RULE10 - config 01: D modulated, A active
// RULE11 - config 10: A/B modulated with dead band
// RULE12 - config 11: B modulated, C active
// RULE13 - duty is high byte plus two low bits
// RULE14 - active memory bus steals B and C
// RULE15 - 12-bit address mode keeps B and C
// RULE16 - remap clear moves B/C to alternate pins
// RULE17 - second unit A pin select and alternates
// RULE18 - quad mode D overrides standard unit pin
// RULE19 - software sets mode, config and directions
// RULE20 - period wrap clears timer, sets, latches duty
// RULE21 - shadow match clears; oversize duty never clears
// RULE22 - inactive outputs drive opposite of polarity
module ecs_top
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic capture_in,
	input wire ecs_pkg::ecs_sys_type sys_in,
	output ecs_pkg::ecs_pins_type pins,
	output ecs_pkg::ecs_event_type events
);
	import ecs_pkg::*;

	typedef struct packed {
		ecs_bus_type bph;
		logic [7:0] baddr;
		logic [31:0] rdata;
		logic [7:0] ctl;
		logic [7:0] duty_hi;
		logic [7:0] period;
		logic [15:0] cmp;
		logic [15:0] cfg;
		logic [9:0] shadow;
		logic [1:0] flags;
		logic [15:0] capt;
		logic [15:0] ctim;
		logic [9:0] ptim;
		logic pwm_raw;
		logic cmp_out;
		logic [6:0] db_cnt;
		logic [3:0] pre_cnt;
		logic [2:0] sync;
		logic [3:0] mode_prev;
		ecs_pins_type pins;
		ecs_event_type ev;
	} ecs_state_type;

	ecs_state_type st_q;
	ecs_state_type st_d;

	// ****************************************************************
	// decoded views of the state
	// ****************************************************************
	logic [3:0] mode;
	logic [1:0] ocfg;
	logic pwm_mode;
	logic pol_ac;
	logic pol_bd;
	logic [9:0] duty;
	logic [1:0] unit;
	logic unit13;
	logic cmp_match;
	logic pwm_wrap;
	logic rise;
	logic fall;
	logic db_done;
	logic [1:0] wclr;
	logic [31:0] rd_value;

	assign mode = st_q.ctl[3:0];
	assign ocfg = st_q.ctl[7:6];
	assign pwm_mode = (mode[3:2] == 2'b11); // see RULE7
	assign pol_ac = st_q.ctl[1]; // see RULE7
	assign pol_bd = st_q.ctl[0]; // see RULE7
	assign duty = {st_q.duty_hi, st_q.ctl[5:4]}; // see RULE13
	assign unit = st_q.cfg[ECS_CFG_UNIT_LO+1:ECS_CFG_UNIT_LO];
	assign unit13 = (unit != ECS_UNIT_SECOND);
	assign cmp_match = (st_q.ctim == st_q.cmp);
	assign pwm_wrap = (st_q.ptim == {st_q.period, 2'b11});
	assign rise = st_q.sync[1] & ~st_q.sync[2];
	assign fall = ~st_q.sync[1] & st_q.sync[2];
	assign db_done = (st_q.db_cnt >= st_q.cfg[ECS_CFG_DB_LO+6:ECS_CFG_DB_LO]);

	// bus outputs: zero wait, always okay
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = st_q.rdata;
	assign pins = st_q.pins;
	assign events = st_q.ev;

	// read mux for the address phase
	always_comb
	begin
		case (haddr)
			ECS_OFF_CTRL: rd_value = {24'h000000, st_q.ctl};
			ECS_OFF_DUTY: rd_value = {24'h000000, st_q.duty_hi};
			ECS_OFF_PERIOD: rd_value = {24'h000000, st_q.period};
			ECS_OFF_COMPARE: rd_value = {16'h0000, st_q.cmp};
			ECS_OFF_STATUS: rd_value = {30'h0, st_q.flags};
			ECS_OFF_SHADOW: rd_value = {22'h0, st_q.shadow};
			ECS_OFF_CONFIG: rd_value = {16'h0000, st_q.cfg};
			ECS_OFF_CAPTURE: rd_value = {16'h0000, st_q.capt};
			default: rd_value = 32'h00000000;
		endcase
	end

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb
	begin
		logic a_act;
		logic b_act;
		logic c_act;
		logic d_act;
		logic a_drv;
		logic b_drv;
		logic c_drv;
		logic d_drv;
		logic bc_lost;
		logic quad;
		logic do_capt;
		logic [1:0] fset;
		a_act = 1'b0;
		b_act = 1'b0;
		c_act = 1'b0;
		d_act = 1'b0;
		a_drv = 1'b0;
		b_drv = 1'b0;
		c_drv = 1'b0;
		d_drv = 1'b0;
		bc_lost = 1'b0;
		quad = 1'b0;
		do_capt = 1'b0;
		fset = 2'b00;
		wclr = 2'b00;
		st_d = st_q;
		st_d.ev = '0;
		st_d.mode_prev = mode;
		// pin synchroniser, first stage read only by the second
		st_d.sync = {st_q.sync[1:0], capture_in};

		// bus address phase
		st_d.bph = ECS_BUS_IDLE;
		if (hsel && htrans[1] && hready)
		begin
			st_d.baddr = haddr;
			st_d.bph = hwrite ? ECS_BUS_WRITE : ECS_BUS_READ;
			st_d.rdata = hwrite ? st_q.rdata : rd_value;
		end

		// bus data phase write
		if (st_q.bph == ECS_BUS_WRITE)
		begin
			case (st_q.baddr)
				ECS_OFF_CTRL: st_d.ctl = hwdata[7:0];
				ECS_OFF_DUTY: st_d.duty_hi = hwdata[7:0];
				ECS_OFF_PERIOD: st_d.period = hwdata[7:0];
				ECS_OFF_COMPARE: st_d.cmp = hwdata[15:0];
				ECS_OFF_STATUS: wclr = hwdata[1:0];
				ECS_OFF_CONFIG: st_d.cfg = hwdata[15:0];
				default: st_d.cfg = st_q.cfg;
			endcase
		end

		// engine
		if (mode == ECS_M_OFF || mode == ECS_M_RSVD)
		begin
			// disabled unit holds its timers and latches cleared
			st_d.ctim = 16'h0000; // see RULE1
			st_d.ptim = 10'h000; // see RULE1
			st_d.pwm_raw = 1'b0; // see RULE1
			st_d.cmp_out = 1'b0; // see RULE1
			st_d.pre_cnt = 4'h0; // see RULE1
			st_d.db_cnt = 7'h00; // see RULE1
		end
		else if (pwm_mode)
		begin
			if (pwm_wrap)
			begin
				st_d.ptim = 10'h000; // see RULE20
				st_d.pwm_raw = (duty != 10'h000); // see RULE20
				st_d.shadow = duty; // see RULE20
			end
			else
			begin
				st_d.ptim = st_q.ptim + 10'h001;
				// duty beyond period never meets the timer
				if (st_q.shadow == st_d.ptim)
					st_d.pwm_raw = 1'b0; // see RULE21
			end
			// dead band restarts on each edge of the raw wave
			if (st_d.pwm_raw != st_q.pwm_raw)
				st_d.db_cnt = 7'h00; // see RULE11
			else if (!db_done)
				st_d.db_cnt = st_q.db_cnt + 7'h01;
		end
		else
		begin
			st_d.ctim = st_q.ctim + 16'h0001;
			if (mode != st_q.mode_prev)
			begin
				st_d.pre_cnt = 4'h0;
				if (mode == ECS_M_CMP_HI)
					st_d.cmp_out = 1'b0; // see RULE4
				if (mode == ECS_M_CMP_LO)
					st_d.cmp_out = 1'b1; // see RULE4
			end
			else if (cmp_match)
			begin
				case (mode)
					ECS_M_TOGGLE: st_d.cmp_out = ~st_q.cmp_out; // see RULE3
					ECS_M_CMP_HI:
					begin
						st_d.cmp_out = 1'b1; // see RULE4
						fset[ECS_ST_MATCH] = 1'b1; // see RULE4
					end
					ECS_M_CMP_LO:
					begin
						st_d.cmp_out = 1'b0; // see RULE4
						fset[ECS_ST_MATCH] = 1'b1; // see RULE4
					end
					ECS_M_CMP_SW: fset[ECS_ST_MATCH] = 1'b1; // see RULE5
					ECS_M_CMP_EVT:
					begin
						fset[ECS_ST_MATCH] = 1'b1; // see RULE6
						if (unit != ECS_UNIT_THIRD)
						begin
							st_d.ctim = 16'h0000; // see RULE6
							st_d.ev.timer_reset = 1'b1; // see RULE6
							st_d.ev.adc_start = st_q.cfg[ECS_CFG_ADC];
						end
					end
					default: st_d.cmp_out = st_q.cmp_out;
				endcase
			end
			// capture edges and prescaler
			case (mode)
				ECS_M_CAP_ANY: do_capt = rise | fall;
				ECS_M_CAP_FALL: do_capt = fall; // see RULE2
				ECS_M_CAP_RISE: do_capt = rise; // see RULE2
				ECS_M_CAP_R4, ECS_M_CAP_R16:
				begin
					if (rise)
					begin
						st_d.pre_cnt = st_q.pre_cnt + 4'h1;
						if (st_q.pre_cnt == ((mode == ECS_M_CAP_R4) ?
							ECS_PRE_R4 : ECS_PRE_R16))
						begin
							st_d.pre_cnt = 4'h0;
							do_capt = 1'b1; // see RULE2
						end
					end
				end
				default: do_capt = 1'b0;
			endcase
			if (do_capt)
			begin
				st_d.capt = st_q.ctim; // see RULE2
				fset[ECS_ST_CAPT] = 1'b1;
			end
		end

		// sticky flags: a set in the clearing cycle wins
		st_d.flags = (st_q.flags & ~wclr) | fset;

		// output roles per configuration
		if (pwm_mode)
		begin
			case (ocfg)
				ECS_OC_SINGLE:
				begin
					a_act = st_q.pwm_raw; // see RULE9
					a_drv = 1'b1;
				end
				ECS_OC_FWD:
				begin
					a_act = 1'b1; // see RULE10
					d_act = st_q.pwm_raw; // see RULE10
					{a_drv, b_drv, c_drv, d_drv} = 4'hf;
				end
				ECS_OC_HALF:
				begin
					a_act = st_q.pwm_raw & db_done; // see RULE11
					b_act = ~st_q.pwm_raw & db_done; // see RULE11
					{a_drv, b_drv} = 2'h3;
				end
				default:
				begin
					b_act = st_q.pwm_raw; // see RULE12
					c_act = 1'b1; // see RULE12
					{a_drv, b_drv, c_drv, d_drv} = 4'hf;
				end
			endcase
			quad = ocfg[0];
		end
		else
		begin
			// configuration field ignored outside pwm
			a_act = st_q.cmp_out; // see RULE8
			a_drv = (mode == ECS_M_TOGGLE) || (mode == ECS_M_CMP_HI) ||
				(mode == ECS_M_CMP_LO); // see RULE5
		end

		// polarity: inactive drives opposite of active
		a_act = a_act ^ pol_ac; // see RULE22
		c_act = c_act ^ pol_ac; // see RULE22
		b_act = b_act ^ pol_bd; // see RULE22
		d_act = d_act ^ pol_bd; // see RULE22
		if (!pwm_mode)
			a_act = st_q.cmp_out;

		// memory bus takes b/c unless 12-bit addressing
		bc_lost = unit13 && st_q.cfg[ECS_CFG_REMAP] && sys_in.bus_active &&
			(st_q.cfg[ECS_CFG_MEM_LO+1:ECS_CFG_MEM_LO] != ECS_MEM_ADDR12);
		st_d.pins = '0;
		st_d.pins.b_lvl = b_act;
		st_d.pins.c_lvl = c_act;
		st_d.pins.balt_lvl = b_act;
		st_d.pins.calt_lvl = c_act;
		if (!unit13 || st_q.cfg[ECS_CFG_REMAP])
		begin
			st_d.pins.b_own = b_drv & ~bc_lost; // see RULE14 see RULE15
			st_d.pins.c_own = c_drv & ~bc_lost; // see RULE14 see RULE15
		end
		else
		begin
			st_d.pins.balt_own = b_drv; // see RULE16
			st_d.pins.calt_own = c_drv; // see RULE16
		end

		// a output placement
		st_d.pins.a_lvl = a_act;
		st_d.pins.a2_lvl = a_act;
		st_d.pins.a3_lvl = a_act;
		if (unit13 || st_q.cfg[ECS_CFG_PINSEL])
			st_d.pins.a_own = a_drv; // see RULE17
		else if (sys_in.ext_mode)
			st_d.pins.a3_own = a_drv; // see RULE17
		else
			st_d.pins.a2_own = a_drv; // see RULE17

		// d output: own pin or the standard unit's pin
		st_d.pins.d_lvl = d_act;
		st_d.pins.d_own = d_drv & ~unit13;
		st_d.pins.shared_lvl = (unit13 && quad) ? d_act :
			sys_in.std_unit_out; // see RULE18
	end

	// state register
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			st_q <= '0;
			st_q.ctl <= ECS_RST_CTRL;
			st_q.duty_hi <= ECS_RST_DUTY;
			st_q.period <= ECS_RST_PERIOD;
			st_q.cmp <= ECS_RST_COMPARE;
			st_q.cfg <= ECS_RST_CONFIG;
		end
		else
			st_q <= st_d;
	end

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_rise;
		st_q.sync[1] && !st_q.sync[2];
	endsequence

	sequence s_rise_mode;
		mode == ECS_M_CAP_RISE && mode == st_q.mode_prev;
	endsequence

	a_disable_clears: assert property ( // see RULE1
		mode == ECS_M_OFF |=> st_q.ptim == 10'h000 && st_q.ctim == 16'h0000)
		else $error("disabled unit kept timer state");

	a_capture_rise: assert property ( // see RULE2
		s_rise_mode and s_rise |=> st_q.capt == $past(st_q.ctim))
		else $error("rising edge capture missed");

	a_toggle_match: assert property ( // see RULE3
		mode == ECS_M_TOGGLE && st_q.mode_prev == mode && cmp_match
		|=> st_q.cmp_out != $past(st_q.cmp_out))
		else $error("compare toggle missed");

	a_set_flag: assert property ( // see RULE4
		mode == ECS_M_CMP_HI && st_q.mode_prev == mode && cmp_match
		|=> st_q.cmp_out && st_q.flags[ECS_ST_MATCH])
		else $error("set on match failed");

	a_flag_only: assert property ( // see RULE5
		mode == ECS_M_CMP_SW |=> !st_q.pins.a_own && !st_q.pins.a2_own)
		else $error("pin driven in flag only mode");

	a_special_event: assert property ( // see RULE6
		mode == ECS_M_CMP_EVT && st_q.mode_prev == mode && cmp_match &&
		unit == 2'h0 |=> st_q.ctim == 16'h0000 && st_q.ev.timer_reset)
		else $error("special event missing");

	a_config_ignored: assert property ( // see RULE8
		!pwm_mode |=> !st_q.pins.b_own && !st_q.pins.c_own &&
		!st_q.pins.d_own)
		else $error("b c d driven outside pwm");

	a_fwd_bridge: assert property ( // see RULE10
		pwm_mode && ocfg == ECS_OC_FWD
		|=> st_q.pins.a_lvl == !$past(pol_ac) &&
		st_q.pins.c_lvl == $past(pol_ac))
		else $error("forward bridge levels wrong");

	a_wrap_latch: assert property ( // see RULE20
		pwm_mode && pwm_wrap
		|=> st_q.ptim == 10'h000 && st_q.shadow == $past(duty) ##1
		(st_q.ptim == 10'h001 || !$past(pwm_mode)))
		else $error("period wrap wrong");

	a_duty_clear: assert property ( // see RULE21
		pwm_mode && !pwm_wrap && st_q.shadow == st_q.ptim + 10'h001
		|=> !st_q.pwm_raw)
		else $error("duty match did not clear");

	a_quad_override: assert property ( // see RULE18
		pwm_mode && unit13 && ocfg[0]
		|=> st_q.pins.shared_lvl == ($past(st_q.pwm_raw &&
		ocfg == ECS_OC_FWD) ^ $past(pol_bd)))
		else $error("quad d override wrong");

endmodule

`default_nettype wire

// [tb/ecs_bridge_model.sv]
// Purpose: behavioural bridge driver stage fed by the unit's pins
// Assumes: bridge gate inputs carry pull-downs
// Notes: gate_q holds a, b, c, d gate levels, one cycle late
`timescale 1ns/10ps
`default_nettype none
module ecs_bridge_model
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire ecs_pkg::ecs_pins_type pins,
	output logic [3:0] gate_q
);
	import ecs_pkg::*;

	// ****************************************************************
	// gate latch
	// ****************************************************************
	// a pin that the unit does not drive reads as its pull-down level
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			gate_q <= 4'h0;
		else
			gate_q <= {pins.d_lvl & pins.d_own, pins.c_lvl & pins.c_own,
				pins.b_lvl & pins.b_own, pins.a_lvl & pins.a_own};
	end
endmodule
`default_nettype wire

// [tb/ecs_top_tb_top.sv]
// Purpose: self-checking bench of the pwm/compare unit
// Assumes: zero-wait slave, hready looped back from hreadyout
// Notes: drivers queue expectations, one monitor compares them
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) \
	begin \
		compares++; \
		if ((g) !== (e)) \
		begin \
			err_total++; \
			$display("MISMATCH %s exp %h got %h", nm, e, g); \
		end \
	end
module ecs_top_tb_top;
	import ecs_pkg::*;
	typedef struct packed {
		logic [1:0] kind;
		logic [31:0] exp;
	} ecs_note_type;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, capture_in;
	logic rd_phase, chk_go, cnt_clr;
	logic [7:0] haddr, hi_cnt, own;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] hwdata, hrdata, obs, rnd;
	logic [15:0] ev_cnt;
	logic [16:0] pv;
	logic [3:0] gate;
	ecs_sys_type sys_in;
	ecs_pins_type pins;
	ecs_event_type events;
	ecs_note_type n;
	ecs_note_type note_q[$];
	int err_total, compares, seed, i, j;
	logic [7:0] offs[8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18,
		8'h40};
	logic [31:0] rv[8] = '{32'h0, 32'h0, 32'hff, 32'hffff, 32'h0, 32'h0,
		32'h3, 32'h0};
	logic [9:0] dd[4] = '{10'h2, 10'h0, 10'h5, 10'h3ff};
	logic [7:0] pp[4] = '{8'h0, 8'h0, 8'h1, 8'h0};
	logic [7:0] hc[4] = '{8'h8, 8'h0, 8'ha, 8'h10};
	logic [7:0] rc[6] = '{8'h03, 8'h0b, 8'h02, 8'h03, 8'h11, 8'h11};
	logic [2:0] rs[6] = '{3'h4, 3'h4, 3'h4, 3'h5, 3'h0, 3'h2};
	logic [7:0] rt[6] = '{8'h7c, 8'h7c, 8'h7c, 8'h3c, 8'h3c, 8'h3c};
	logic [16:0] re[6] = '{17'h18080, 17'h19880, 17'h18680, 17'h18080,
		17'h04040, 17'h02020};
	logic [7:0] ct[4] = '{8'hc8, 8'h09, 8'h0a, 8'h02};
	logic [16:0] cb[4] = '{17'h8000, 17'h8080, 17'h0, 17'h8000};
	logic [16:0] ca[4] = '{17'h8080, 17'h8000, 17'h0, 17'h8080};
	logic [3:0] cm[5] = '{4'h4, 4'h3, 4'h5, 4'h6, 4'h7};
	int cn[5] = '{1, 1, 1, 4, 16};

	// ****************************************************************
	// design and far side
	// ****************************************************************
	ecs_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .capture_in(capture_in), .sys_in(sys_in),
		.pins(pins), .events(events));
	ecs_bridge_model bridge (.hclk(hclk), .hresetn(hresetn), .pins(pins),
		.gate_q(gate));

	// owned pins and their levels, shared pin on top
	assign own = {pins.a_own, pins.a2_own, pins.a3_own, pins.b_own,
		pins.c_own, pins.balt_own, pins.calt_own, pins.d_own};
	assign pv = {pins.shared_lvl, own, own & {pins.a_lvl, pins.a2_lvl,
		pins.a3_lvl, pins.b_lvl, pins.c_lvl, pins.balt_lvl, pins.calt_lvl,
		pins.d_lvl}};

	// clock of 40 ns
	initial
	begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end

	// ****************************************************************
	// monitor
	// ****************************************************************
	// windowed counts of the a gate and of the event pulses
	always @(posedge hclk)
	begin
		if (cnt_clr)
		begin
			hi_cnt <= 8'h0;
			ev_cnt <= 16'h0;
		end
		else
		begin
			hi_cnt <= hi_cnt + {7'h0, gate[0]};
			ev_cnt <= ev_cnt + {7'h0, events.adc_start, 7'h0,
				events.timer_reset};
		end
	end

	// oldest note is compared when read data or a check strobe appears
	always @(posedge hclk)
	begin
		if (rd_phase && hreadyout === 1'b1)
		begin
			n = note_q.pop_front();
			`CHK("hrdata", n.exp, hrdata)
			`CHK("hresp", 1'b0, hresp)
		end
		if (chk_go)
		begin
			n = note_q.pop_front();
			case (n.kind)
				2'h1: obs = {15'h0, pv};
				2'h2: obs = {24'h0, hi_cnt};
				default: obs = {16'h0, ev_cnt};
			endcase
			`CHK("outputs", n.exp, obs)
		end
	end

	// ****************************************************************
	// drivers
	// ****************************************************************
	// one single ahb-lite transfer, address phase held until hready
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [31:0] e);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		if (!w)
			note_q.push_back('{2'h0, e});
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rd_phase <= !w;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		rd_phase <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 32'h0);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0, e);
	endtask

	// queue a note and strobe the monitor for one cycle
	task automatic chk(input logic [1:0] k, input logic [31:0] e);
		note_q.push_back('{k, e});
		@(posedge hclk);
		chk_go <= 1'b1;
		@(posedge hclk);
		chk_go <= 1'b0;
	endtask

	// count over sixteen cycles, then check
	task automatic cnt(input logic [1:0] k, input logic [31:0] e);
		@(posedge hclk);
		cnt_clr <= 1'b1;
		@(posedge hclk);
		cnt_clr <= 1'b0;
		repeat (15) @(posedge hclk);
		chk(k, e);
	endtask

	task automatic pin_edge(input logic v);
		@(posedge hclk);
		capture_in <= v;
		repeat (6) @(posedge hclk);
	endtask

	// bridge levels: a/c polarity p[1], b/d polarity p[0], output raw set
	function automatic logic [31:0] bexp(input logic [1:0] oc,
		input logic [1:0] p);
		logic [7:0] o;
		logic [7:0] l;
		o = 8'h99;
		l = {!p[1], 2'h0, p[0], p[1], 2'h0, !p[0]};
		case (oc)
			2'h0: o = 8'h80;
			2'h2: o = 8'h90;
			2'h3: l = {p[1], 2'h0, !p[0], !p[1], 2'h0, p[0]};
			default: o = 8'h99;
		endcase
		bexp = {16'h0, o, o & l};
	endfunction

	task close_out;
		$display("checks %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// watchdog against a hang
	initial
	begin
		repeat (20000) @(posedge hclk);
		err_total++;
		close_out();
	end

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial
	begin
		{hresetn, hsel, hwrite, capture_in, rd_phase, chk_go, cnt_clr} = 7'h0;
		{haddr, htrans, hsize, hwdata, sys_in} = '0;
		{err_total, compares} = '0;
		seed = 32'he719;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		hsize <= 3'h2;
		for (i = 0; i < 8; i++)
			rd(offs[i], rv[i]);
		rnd = $random(seed);
		wr(ECS_OFF_DUTY, rnd);
		rd(ECS_OFF_DUTY, {24'h0, rnd[7:0]});
		wr(ECS_OFF_CTRL, 32'hffffff35);
		rd(ECS_OFF_CTRL, 32'h35);
		wr(ECS_OFF_CONFIG, 32'h13);
		for (i = 0; i < 4; i++)
		begin
			// idle unit clears its timer, so a shorter period cannot overrun
			wr(ECS_OFF_CTRL, 32'h0);
			wr(ECS_OFF_PERIOD, {24'h0, pp[i]});
			wr(ECS_OFF_DUTY, {24'h0, dd[i][9:2]});
			wr(ECS_OFF_CTRL, {26'h0, dd[i][1:0], 4'hc});
			repeat (20) @(posedge hclk);
			cnt(2'h2, {24'h0, hc[i]});
			rd(ECS_OFF_SHADOW, {22'h0, dd[i]});
		end
		for (i = 0; i < 16; i++)
		begin
			wr(ECS_OFF_CTRL, {24'h0, i[3:2], 4'hf, i[1:0]});
			repeat (12) @(posedge hclk);
			rnd = bexp(i[3:2], i[1:0]);
			chk(2'h1, rnd);
		end
		for (i = 0; i < 6; i++)
		begin
			sys_in <= rs[i];
			wr(ECS_OFF_CONFIG, {24'h0, rc[i]});
			wr(ECS_OFF_CTRL, {24'h0, rt[i]});
			repeat (12) @(posedge hclk);
			chk(2'h1, {15'h0, re[i]});
		end
		sys_in <= '0;
		wr(ECS_OFF_CONFIG, 32'h13);
		for (i = 0; i < 2; i++)
		begin
			wr(ECS_OFF_CTRL, 32'h7c);
			wr(ECS_OFF_CTRL, i);
			repeat (4) @(posedge hclk);
			chk(2'h1, 32'h0);
		end
		wr(ECS_OFF_COMPARE, 32'h10);
		for (i = 0; i < 4; i++)
		begin
			wr(ECS_OFF_CTRL, 32'h0);
			wr(ECS_OFF_STATUS, 32'h3);
			wr(ECS_OFF_CTRL, {24'h0, ct[i]});
			repeat (2) @(posedge hclk);
			chk(2'h1, {15'h0, cb[i]});
			repeat (30) @(posedge hclk);
			chk(2'h1, {15'h0, ca[i]});
			rd(ECS_OFF_STATUS, (i == 3) ? 32'h0 : 32'h1);
		end
		wr(ECS_OFF_COMPARE, 32'h3);
		for (i = 0; i < 2; i++)
		begin
			wr(ECS_OFF_CTRL, 32'h0);
			wr(ECS_OFF_CONFIG, i ? 32'h63 : 32'h43);
			wr(ECS_OFF_STATUS, 32'h3);
			wr(ECS_OFF_CTRL, 32'h0b);
			repeat (4) @(posedge hclk);
			cnt(2'h3, i ? 32'h0 : 32'h0404);
			rd(ECS_OFF_STATUS, 32'h1);
		end
		wr(ECS_OFF_CONFIG, 32'h13);
		for (i = 0; i < 5; i++)
		begin
			wr(ECS_OFF_CTRL, 32'h0);
			wr(ECS_OFF_STATUS, 32'h3);
			wr(ECS_OFF_CTRL, {28'h0, cm[i]});
			for (j = 1; j < cn[i]; j++)
			begin
				pin_edge(1'b1);
				pin_edge(1'b0);
			end
			rd(ECS_OFF_STATUS, 32'h0);
			pin_edge(1'b1);
			rd(ECS_OFF_STATUS, i ? 32'h2 : 32'h0);
			pin_edge(1'b0);
			rd(ECS_OFF_STATUS, 32'h2);
		end
		close_out();
	end
endmodule
`default_nettype wire
